// ===== emp_cpu_model.sv
// Processor core model: issues one memory cycle per bench command.
// Assumes commands change just after rising edges of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module emp_cpu_model
    import emp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire emp_pkg::emp_cpu_req_t cmd,
    output emp_pkg::emp_cpu_req_t cpu_req
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cpu_req <= '0;
        end else if (cmd.valid) begin
            cpu_req <= cmd;
        end else begin
            // Idle lines never hold the last cycle
            cpu_req <= '{valid: 1'b0, write: ~cpu_req.write, addr: ~cpu_req.addr};
        end
    end
endmodule
`default_nettype wire

// ===== emp_entry_ram.sv
// Translation entry store: one 16-bit word per mapped 16 KB window.
// Assumes a single clock; one write port, two registered read ports.
`timescale 1ns/1ns
`default_nettype none
module emp_entry_ram #(
    parameter int DEPTH = 26,
    parameter int WIDTH = 16,
    parameter int AW = 5
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr_a,
    output logic [WIDTH-1:0] rd_data_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [WIDTH-1:0] rd_data_b
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Reset clears every entry so all pages start disabled
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (srst) begin
                mem_reg[i] <= '0;
            end else if (wr_en && wr_addr == AW'(i)) begin
                mem_reg[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else begin
            rd_data_a <= (int'(rd_addr_a) < DEPTH) ? mem_reg[rd_addr_a] : '0;
            rd_data_b <= (int'(rd_addr_b) < DEPTH) ? mem_reg[rd_addr_b] : '0;
        end
    end
endmodule
`default_nettype wire

// ===== emp_mapper.sv
// Expanded-memory page mapper: indexed entry table behind Avalon-MM,
// and the translation of processor memory cycles in 8000:0 - B7FF:F and C000:0 - EFFF:F.
// Assumes synchronous inputs on clk_sys and a master that holds requests.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: Bits 7:2 of the entry-select register pick the entry the two data registers reach.
// R2: Software only loads legal entry values 80-B4 and C0-EC in steps of four.
// R3: Bits 1:0 of entry-select drop writes and read back zero.
// R4: The low data register carries frame bits 21:14 of the selected entry.
// R5: High data bits 3:0 carry frame bits 25:22, making a twelve-bit frame.
// R6: High data bit 7 enables remapping of the page and resets to zero.
// R7: High data bits 6:4 pick external bus, RAM, ROM0, ROM1, card A or card B.
// R8: A RAM page takes its RAM kind from the separate four-bit setting.
// R9: Entry value V covers the 16 KB window whose segment base is V followed by 00.
// R10: An enabled page keeps address bits 13:0 and takes its frame above them.
// R11: A disabled or unmapped cycle passes untranslated to default decode.
module emp_mapper
    import emp_pkg::*;
#(
    parameter int ENTRIES = 26
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire emp_pkg::emp_cpu_req_t cpu_req,
    output emp_pkg::emp_mem_req_t mem_req
);
    import emp_pkg::*;

    // Window segment base bits 19:14 to table index, or all ones if unmapped
    function automatic logic [4:0] window_index(input logic [5:0] page);
        logic [7:0] v;
        v = {page, 2'b00};
        if (v >= ENTRY_FIRST_LO && v <= ENTRY_LAST_LO) begin
            window_index = 5'(page - 6'h20);
        end else if (v >= ENTRY_FIRST_HI && v <= ENTRY_LAST_HI) begin
            window_index = 5'(page - 6'h20) - ENTRY_GAP;
        end else begin
            window_index = 5'h1f;
        end
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_DONE = 3'b100
    } emp_bus_st_t;

    emp_bus_st_t st_reg;
    emp_bus_st_t st_next;
    logic [SEL_W-1:0] entry_sel_reg;
    logic [3:0] ram_kind_setting_reg;
    logic [31:0] rdata_next;
    logic wr_en;
    logic [ENTRY_W-1:0] wr_data;
    logic [ENTRY_W-1:0] sel_entry;
    logic [ENTRY_W-1:0] cpu_entry;
    logic [4:0] sel_idx;
    logic [4:0] cpu_idx;
    emp_cpu_req_t cpu_req_reg;
    logic [4:0] cpu_idx_reg;
    logic bus_req;
    logic bus_wr;

    assign bus_req = avs_read | avs_write;
    assign bus_wr = avs_write & avs_byteenable[0];
    assign sel_idx = window_index(entry_sel_reg); // [R1]
    assign cpu_idx = window_index(cpu_req.addr[19:14]); // [R9]

    // Bus: IDLE -> FETCH (entry read out of memory) -> DONE (answer)
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (bus_req) begin
                    st_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                st_next = ST_DONE;
            end
            ST_DONE: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest = bus_req & (st_reg != ST_DONE);

    // Entry-select and RAM-kind registers update at the answering edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            entry_sel_reg <= RST_ENTRY_SELECT[7:2];
            ram_kind_setting_reg <= RST_RAM_KIND;
        end else if (st_reg == ST_DONE && bus_wr) begin
            if (avs_address == ADDR_ENTRY_SELECT) begin
                entry_sel_reg <= avs_writedata[7:SEL_LSB]; // [R1] [R3]
            end
            if (avs_address == ADDR_RAM_KIND) begin
                ram_kind_setting_reg <= avs_writedata[3:0];
            end
        end
    end

    // Read-modify-write of the selected entry, merging one byte
    always_comb begin
        wr_data = sel_entry;
        wr_en = 1'b0;
        if (st_reg == ST_DONE && bus_wr && sel_idx != 5'h1f) begin
            if (avs_address == ADDR_FRAME_LOW) begin
                wr_en = 1'b1;
                wr_data[7:0] = avs_writedata[7:0]; // [R4]
            end else if (avs_address == ADDR_FRAME_HIGH_CTRL) begin
                wr_en = 1'b1;
                wr_data[15:8] = avs_writedata[7:0]; // [R5] [R6] [R7]
            end
        end
    end

    always_comb begin
        rdata_next = UNMAPPED_READ;
        if (avs_address == ADDR_ENTRY_SELECT) begin
            rdata_next[7:0] = {entry_sel_reg, 2'b00}; // [R3]
        end else if (avs_address == ADDR_FRAME_LOW) begin
            rdata_next[7:0] = sel_entry[7:0]; // [R4]
        end else if (avs_address == ADDR_FRAME_HIGH_CTRL) begin
            rdata_next[7:0] = sel_entry[15:8]; // [R5] [R6] [R7]
        end else if (avs_address == ADDR_RAM_KIND) begin
            rdata_next[3:0] = ram_kind_setting_reg;
        end
    end

    // Read data registered in FETCH so it stands at the answering edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            avs_readdata <= UNMAPPED_READ;
        end else if (st_reg == ST_FETCH) begin
            avs_readdata <= rdata_next;
        end
    end

    emp_entry_ram #(
        .DEPTH(ENTRIES),
        .WIDTH(ENTRY_W),
        .AW(5)
    ) u_entries (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(wr_en),
        .wr_addr(sel_idx),
        .wr_data(wr_data),
        .rd_addr_a(sel_idx),
        .rd_data_a(sel_entry),
        .rd_addr_b(cpu_idx),
        .rd_data_b(cpu_entry)
    );

    // Processor cycle stage aligned with the registered entry read
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cpu_req_reg <= '0;
            cpu_idx_reg <= 5'h1f;
        end else begin
            cpu_req_reg <= cpu_req;
            cpu_idx_reg <= cpu_idx;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_req <= '0;
        end else begin
            mem_req.valid <= cpu_req_reg.valid;
            mem_req.write <= cpu_req_reg.write;
            mem_req.ram_kind <= ram_kind_setting_reg; // [R8]
            if (cpu_idx_reg != 5'h1f && cpu_entry[HIGH_EN_BIT + 8]) begin
                mem_req.mapped <= 1'b1;
                mem_req.addr <= {cpu_entry[11:0], cpu_req_reg.addr[PAGE_OFS_W-1:0]}; // [R10]
                mem_req.target <= emp_target_t'(cpu_entry[14:12]); // [R7]
            end else begin
                mem_req.mapped <= 1'b0; // [R11]
                mem_req.addr <= {6'h00, cpu_req_reg.addr};
                mem_req.target <= EMP_TGT_EXT_BUS;
            end
        end
    end
endmodule
`default_nettype wire

// ===== emp_mapper_props.sv
// Checker for the page mapper: bus answer timing and cycle translation.
// Assumes it sees only the mapper's top ports; bound at the foot.
`timescale 1ns/1ns
`default_nettype none
module emp_mapper_props
    import emp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire emp_pkg::emp_cpu_req_t cpu_req,
    input wire emp_pkg::emp_mem_req_t mem_req
);
    logic out_win;
    // Below 8000:0, in the B800 gap, or from F000:0 up
    assign out_win = !cpu_req.addr[19] || cpu_req.addr[19:16] == 4'hf || cpu_req.addr[19:15] == 5'b10111;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    wait_two_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer timing");
    sel_low_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_ENTRY_SELECT |->
        avs_readdata[1:0] == 2'b00) else $error("select low bits");
    valid_lat_a: assert property (cpu_req.valid |-> ##2 mem_req.valid) else $error("cycle lost");
    write_lat_a: assert property (cpu_req.valid |-> ##2 mem_req.write == $past(cpu_req.write, 2))
        else $error("direction changed");
    pass_thru_a: assert property (cpu_req.valid && out_win |->
        ##2 !mem_req.mapped && mem_req.addr == {6'h00, $past(cpu_req.addr, 2)}) else $error("outside translated");
    unmap_ext_a: assert property (mem_req.valid && !mem_req.mapped |-> mem_req.target == EMP_TGT_EXT_BUS)
        else $error("unmapped target");
    offset_keep_a: assert property (mem_req.valid && mem_req.mapped |->
        mem_req.addr[13:0] == $past(cpu_req.addr[13:0], 2) && !$past(out_win, 2)) else $error("offset or window");
    reset_off_a: assert property ($fell(srst) |-> !mem_req.mapped [*3]) else $error("page on after reset");
    cover property (mem_req.mapped && mem_req.target == EMP_TGT_RAM);
    cover property (avs_write && !avs_waitrequest);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind emp_mapper emp_mapper_props i_props (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .mem_req(mem_req));
`default_nettype wire

// ===== emp_pkg.sv
// Package for the expanded-memory page mapper: register map, field layout,
// target device codes and the processor-side carrier structs.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package emp_pkg;

    // Printed offsets are not all multiples of four: they are indices,
    // and the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_ENTRY_SELECT = 8'h6c;
    localparam logic [7:0] IDX_FRAME_LOW = 8'h6e;
    localparam logic [7:0] IDX_FRAME_HIGH_CTRL = 8'h6f;
    localparam logic [7:0] IDX_RAM_KIND = 8'h70;
    localparam logic [9:0] ADDR_ENTRY_SELECT = {IDX_ENTRY_SELECT, 2'b00};
    localparam logic [9:0] ADDR_FRAME_LOW = {IDX_FRAME_LOW, 2'b00};
    localparam logic [9:0] ADDR_FRAME_HIGH_CTRL = {IDX_FRAME_HIGH_CTRL, 2'b00};
    localparam logic [9:0] ADDR_RAM_KIND = {IDX_RAM_KIND, 2'b00};

    localparam logic [7:0] RST_ENTRY_SELECT = 8'h00;
    localparam logic [7:0] RST_FRAME_LOW = 8'h00;
    localparam logic [7:0] RST_FRAME_HIGH_CTRL = 8'h00;
    localparam logic [3:0] RST_RAM_KIND = 4'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Entry table layout
    localparam int NUM_ENTRIES = 26;
    localparam int ENTRY_W = 16;
    localparam int SEL_LSB = 2;
    localparam int SEL_W = 6;
    localparam int HIGH_EN_BIT = 7;
    localparam int HIGH_TYPE_LSB = 4;
    localparam int FRAME_W = 12;
    localparam int PAGE_OFS_W = 14;

    // Legal entry windows, in units of entry_select values
    localparam logic [7:0] ENTRY_FIRST_LO = 8'h80;
    localparam logic [7:0] ENTRY_LAST_LO = 8'hb4;
    localparam logic [7:0] ENTRY_FIRST_HI = 8'hc0;
    localparam logic [7:0] ENTRY_LAST_HI = 8'hec;
    localparam logic [4:0] ENTRY_GAP = 5'd2;

    typedef enum logic [2:0] {
        EMP_TGT_EXT_BUS = 3'b000,
        EMP_TGT_RAM = 3'b001,
        EMP_TGT_ROM0 = 3'b010,
        EMP_TGT_ROM1 = 3'b011,
        EMP_TGT_CARD_A = 3'b100,
        EMP_TGT_CARD_B = 3'b101,
        EMP_TGT_RSVD6 = 3'b110,
        EMP_TGT_RSVD7 = 3'b111
    } emp_target_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [19:0] addr;
    } emp_cpu_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [25:0] addr;
        logic mapped;
        emp_target_t target;
        logic [3:0] ram_kind;
    } emp_mem_req_t;

endpackage

// ===== test_emp_mapper.sv
// Bench for the page mapper: table access over Avalon-MM, then translation.
// Assumes the processor model drives the cycle side.
`timescale 1ns/1ns
`default_nettype none
module test_emp_mapper;
    import emp_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [9:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    emp_cpu_req_t cmd = '0;
    emp_cpu_req_t cpu_req;
    emp_mem_req_t mem_req;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] q;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [13:0] ofs;
    logic [9:0] regs [5] = '{ADDR_ENTRY_SELECT, ADDR_FRAME_LOW, ADDR_FRAME_HIGH_CTRL, ADDR_RAM_KIND, 10'h004};
    logic [19:0] outs [4] = '{20'hc_0123, 20'hb_8001, 20'h7_ffff, 20'hf_0000};
    int k;
    emp_mapper i_dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .mem_req(mem_req));
    emp_cpu_model i_cpu (.clk_sys(clk_sys), .srst(srst), .cmd(cmd), .cpu_req(cpu_req));
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n;
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h00_0000, d};
        // Waitrequest and read data are taken at the rising edge itself
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            n_errors++;
            tally_and_finish();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic cpu(input logic [19:0] a, input logic [25:0] ea, input logic em, input logic [2:0] et);
        emp_mem_req_t e;
        e = '{valid: 1'b1, write: a[0], addr: ea, mapped: em, target: emp_target_t'(et), ram_kind: 4'h9};
        cmd <= '{valid: 1'b1, write: a[0], addr: a};
        @(posedge clk_sys);
        cmd <= '0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(mem_req, e);
        @(posedge clk_sys);
    endtask
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 8'h00);
            chk(q, '0);
        end
        bus(1'b1, ADDR_ENTRY_SELECT, 8'hb7);
        bus(1'b0, ADDR_ENTRY_SELECT, 8'h00);
        chk(q, 32'h0000_00b4);
        // Write without byte lane 0 is answered but dropped
        avs_byteenable <= 4'he;
        bus(1'b1, ADDR_ENTRY_SELECT, 8'hc0);
        avs_byteenable <= 4'hf;
        bus(1'b0, ADDR_ENTRY_SELECT, 8'h00);
        chk(q, 32'h0000_00b4);
        bus(1'b1, ADDR_RAM_KIND, 8'h09);
        bus(1'b0, ADDR_RAM_KIND, 8'h00);
        chk(q, 32'h0000_0009);
        for (int p = 0; p < 2; p++) begin
            k = 0;
            for (int v = 8'h80; v <= 8'hec; v += 4) begin
                if (v == 8'hb8 || v == 8'hbc) continue;
                lo = 8'(v) ^ 8'h5a;
                hi = {1'b1, 3'(k % 6), 4'(k)};
                ofs = k[0] ? 14'h3fff : 14'h1a5c;
                bus(1'b1, ADDR_ENTRY_SELECT, 8'(v));
                if (p == 0) begin
                    bus(1'b1, ADDR_FRAME_LOW, lo);
                    bus(1'b1, ADDR_FRAME_HIGH_CTRL, hi);
                end else begin
                    bus(1'b0, ADDR_FRAME_LOW, 8'h00);
                    chk(q, {24'h00_0000, lo});
                    bus(1'b0, ADDR_FRAME_HIGH_CTRL, 8'h00);
                    chk(q, {24'h00_0000, hi});
                    cpu({6'(v >> 2), ofs}, {hi[3:0], lo, ofs}, 1'b1, hi[6:4]);
                end
                k++;
            end
        end
        bus(1'b1, ADDR_ENTRY_SELECT, 8'hc0);
        bus(1'b1, ADDR_FRAME_HIGH_CTRL, 8'h15);
        foreach (outs[i]) begin
            cpu(outs[i], {6'h00, outs[i]}, 1'b0, 3'b000);
        end
        // Reserved type code on an enabled page is still translated, with target 110 kept
        bus(1'b1, ADDR_ENTRY_SELECT, 8'hc4);
        bus(1'b1, ADDR_FRAME_HIGH_CTRL, 8'he3);
        cpu({6'h31, 14'h0001}, {4'h3, 8'h9e, 14'h0001}, 1'b1, 3'b110);
        tally_and_finish();
    end
endmodule
`default_nettype wire
